/* File: sec_ctrl.v */
// System exception control: priority grouping, low-power wake, configuration traps, APB registers
//
// Added by the designer: the register offsets and the APB slave port.
`include "sec_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module sec_ctrl (
   input  wire        CORE_CLK_I,
   input  wire        SRST_I,
   // APB slave
   input  wire        PSEL_I,
   input  wire        PENABLE_I,
   input  wire        PWRITE_I,
   input  wire [11:0] PADDR_I,
   input  wire [31:0] PWDATA_I,
   input  wire [3:0]  PSTRB_I,
   output wire        PREADY_O,
   output wire [31:0] PRDATA_O,
   output wire        PSLVERR_O,
   // Priority comparison
   input  wire [7:0]  CMP_PRI_A_I,
   input  wire [7:0]  CMP_PRI_B_I,
   output wire        PREEMPT_O,
   output wire [7:0]  GROUP_PRI_A_O,
   output wire [7:0]  SUB_PRI_A_O,
   output wire [7:0]  PRI_MEMFAULT_O,
   output wire [7:0]  PRI_BUSFAULT_O,
   output wire [7:0]  PRI_USAGE_O,
   output wire [7:0]  PRI_SVCALL_O,
   output wire [7:0]  PRI_PENDSV_O,
   output wire [7:0]  PRI_SYSTICK_O,
   // Low power
   input  wire        IRQ_PEND_SET_I,
   input  wire        IRQ_PEND_EN_I,
   input  wire        EVT_PEND_SET_I,
   input  wire        SEV_I,
   input  wire        EXT_EVENT_I,
   input  wire        WFE_I,
   input  wire        RET_TO_THREAD_I,
   output wire        WAKE_O,
   output wire        SLEEPING_O,
   output wire        DEEP_SLEEP_O,
   // Traps
   input  wire        EXC_ENTRY_I,
   input  wire        SP_BIT2_I,
   input  wire        EXCEPTION_RETURN_VALUE_I,
   input  wire        STACKED_BIT9_I,
   output wire        STACK_PAD_O,
   output wire        STACKED_BIT9_O,
   output wire        RESTORE_PAD_O,
   input  wire        DBUS_FAULT_I,
   input  wire        ELEVATED_PRI_I,
   output wire        LOCKUP_O,
   output wire        BUSFAULT_IGNORED_O,
   input  wire        DIV_ZERO_I,
   output wire        DIV_TRAP_O,
   output wire        DIV_QUOT_ZERO_O,
   input  wire        MISALIGNED_I,
   input  wire        MULTI_DOUBLE_I,
   output wire        USAGE_FAULT_O,
   input  wire        TRIG_ACCESS_I,
   input  wire        TRIG_UNPRIV_I,
   output wire        TRIG_ALLOW_O,
   output wire        TRIG_DENY_O,
   input  wire        THREAD_RET_I,
   input  wire        OTHER_ACTIVE_I,
   output wire        THREAD_OK_O,
   output wire        THREAD_FAULT_O
);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Register state
   reg  [2:0]  split_r;
   reg  [31:0] lp_r;
   reg  [31:0] cc_r;
   reg  [7:0]  hpri_r [0:11];
   reg         pready_r;
   reg  [31:0] prdata_r;
   reg         pslverr_r;

   // First access cycle only; ready answers it one clock later
   wire        acc      = PSEL_I & PENABLE_I & ~pready_r;
   // Writes commit on the completing edge, when the master samples ready high
   wire        wr_en    = PSEL_I & PENABLE_I & pready_r & PWRITE_I;
   wire        hit_hpri = (PADDR_I == `SEC_OFS_HPRI1) | (PADDR_I == `SEC_OFS_HPRI2) |
                          (PADDR_I == `SEC_OFS_HPRI3);
   wire        mapped   = (PADDR_I == `SEC_OFS_SPLIT) | (PADDR_I == `SEC_OFS_LPCTRL) |
                          (PADDR_I == `SEC_OFS_CFGCTRL) | hit_hpri;
   wire [1:0]  hsel     = PADDR_I[3:2] - 2'h3;
   wire        key_ok   = (PWDATA_I[31:16] == `SEC_KEY_WRITE) & (&PSTRB_I[3:2]);

   ////////////////////////////////////////////////////////////////////////////////////////////
   // APB access, one wait state on every transfer
   reg [31:0] rd_val;
   always @* begin
      rd_val = 32'h0000_0000;
      case (PADDR_I)
         `SEC_OFS_SPLIT: rd_val = {`SEC_KEY_READ, 5'h00, split_r, 8'h00};
         `SEC_OFS_LPCTRL: rd_val = lp_r;
         `SEC_OFS_CFGCTRL: rd_val = cc_r;
         `SEC_OFS_HPRI1: rd_val = {hpri_r[3], hpri_r[2], hpri_r[1], hpri_r[0]};
         `SEC_OFS_HPRI2: rd_val = {hpri_r[7], hpri_r[6], hpri_r[5], hpri_r[4]};
         `SEC_OFS_HPRI3: rd_val = {hpri_r[11], hpri_r[10], hpri_r[9], hpri_r[8]};
         default: rd_val = 32'h0000_0000;
      endcase
   end

   always @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
         split_r   <= `SEC_SPLIT_RST;
         lp_r      <= 32'h0000_0000;
         cc_r      <= `SEC_CC_RST;
      end else begin
         pready_r  <= acc;
         pslverr_r <= acc & ~mapped;
         prdata_r  <= (acc & ~PWRITE_I) ? rd_val : 32'h0000_0000;
         // Whole write dropped unless the unlock key is present
         if (wr_en && PADDR_I == `SEC_OFS_SPLIT && key_ok && PSTRB_I[1]) begin
            split_r <= PWDATA_I[`SEC_SPLIT_MSB:`SEC_SPLIT_LSB];
         end
         if (wr_en && PADDR_I == `SEC_OFS_LPCTRL && PSTRB_I[0]) begin
            lp_r <= {24'h00_0000, PWDATA_I[7:0]} & `SEC_LP_MASK;
         end
         if (wr_en && PADDR_I == `SEC_OFS_CFGCTRL) begin
            cc_r <= {22'h00_0000,
                     PSTRB_I[1] ? PWDATA_I[9:8] : cc_r[9:8],
                     PSTRB_I[0] ? PWDATA_I[7:0] : cc_r[7:0]} & `SEC_CC_MASK;
         end
      end
   end

   // Byte lanes of the handler priority registers; unused fields stay zero
   genvar g;
   generate
      for (g = 0; g < 12; g = g + 1) begin : g_hpri
         localparam IMPL = (g == 0) | (g == 1) | (g == 2) | (g == 7) | (g == 10) | (g == 11);
         always @(posedge CORE_CLK_I) begin
            if (SRST_I || !IMPL) begin
               hpri_r[g] <= `SEC_PRI_RST;
            end else if (wr_en && hit_hpri && hsel == g / 4 && PSTRB_I[g % 4]) begin
               hpri_r[g] <= PWDATA_I[(g % 4) * 8 +: 8] & `SEC_PRI_IMPL_MASK;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Priority grouping
   reg [7:0] gmask;
   always @* begin
      case (split_r)
         3'h4: gmask = 8'he0;
         3'h5: gmask = 8'hc0;
         3'h6: gmask = 8'h80;
         3'h7: gmask = 8'h00;
         // Split codes below three behave as code three
         default: gmask = 8'hf0;
      endcase
   end

   reg       preempt_r;
   reg [7:0] grp_a_r;
   reg [7:0] sub_a_r;
   always @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         preempt_r <= 1'b0;
         grp_a_r   <= 8'h00;
         sub_a_r   <= 8'h00;
      end else begin
         // Lower value is more urgent; subpriority never decides preemption
         preempt_r <= (CMP_PRI_A_I & gmask) < (CMP_PRI_B_I & gmask);
         grp_a_r   <= CMP_PRI_A_I & gmask;
         sub_a_r   <= CMP_PRI_A_I & ~gmask & `SEC_PRI_IMPL_MASK;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Event latch and low-power state
   // Two-flop synchroniser; only the edge detector reads the second stage
   reg ext_m_r;
   reg ext_s_r;
   reg ext_d_r;
   always @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         ext_m_r <= 1'b0;
         ext_s_r <= 1'b0;
         ext_d_r <= 1'b0;
      end else begin
         ext_m_r <= EXT_EVENT_I;
         ext_s_r <= ext_m_r;
         ext_d_r <= ext_s_r;
      end
   end

   wire ext_evt = ext_s_r & ~ext_d_r;
   wire pend_ev = EVT_PEND_SET_I |
                  (IRQ_PEND_SET_I & (IRQ_PEND_EN_I | lp_r[`SEC_LP_ANY_PEND]));
   wire any_evt = pend_ev | SEV_I | ext_evt;

   reg evt_latch_r;
   reg wfe_wait_r;
   reg sleep_ret_r;
   reg deep_r;
   reg wake_r;
   reg sleeping_r;
   reg deep_out_r;
   reg evt_latch_nxt;
   reg wfe_wait_nxt;
   reg sleep_ret_nxt;
   reg deep_nxt;
   wire wfe_done  = WFE_I & evt_latch_r;
   wire end_wait  = wfe_wait_r & any_evt;
   wire end_sleep = sleep_ret_r & pend_ev;
   wire ret_sleep = RET_TO_THREAD_I & lp_r[`SEC_LP_ON_RETURN];

   // Next state of the wait, sleep and event latch flags
   always @* begin
      evt_latch_nxt = evt_latch_r;
      wfe_wait_nxt  = wfe_wait_r;
      sleep_ret_nxt = sleep_ret_r;
      deep_nxt      = deep_r;
      // A new event in the consuming cycle survives for the next wait
      if (any_evt && !wfe_wait_r) begin
         evt_latch_nxt = 1'b1;
      end else if (wfe_done) begin
         evt_latch_nxt = 1'b0;
      end
      if (end_wait) begin
         wfe_wait_nxt = 1'b0;
      end else if (WFE_I && !evt_latch_r && !any_evt) begin
         wfe_wait_nxt = 1'b1;
      end
      if (end_sleep) begin
         sleep_ret_nxt = 1'b0;
      end else if (ret_sleep) begin
         sleep_ret_nxt = 1'b1;
      end
      // Depth is captured at entry so a later write cannot change a sleep in progress
      if ((WFE_I && !evt_latch_r) || ret_sleep) begin
         deep_nxt = lp_r[`SEC_LP_DEEP];
      end
   end

   // Sleep pins are registered from next state so they come straight from flops
   always @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         evt_latch_r <= 1'b0;
         wfe_wait_r  <= 1'b0;
         sleep_ret_r <= 1'b0;
         deep_r      <= 1'b0;
         sleeping_r  <= 1'b0;
         deep_out_r  <= 1'b0;
         wake_r      <= 1'b0;
      end else begin
         evt_latch_r <= evt_latch_nxt;
         wfe_wait_r  <= wfe_wait_nxt;
         sleep_ret_r <= sleep_ret_nxt;
         deep_r      <= deep_nxt;
         sleeping_r  <= wfe_wait_nxt | sleep_ret_nxt;
         deep_out_r  <= deep_nxt & (wfe_wait_nxt | sleep_ret_nxt);
         wake_r      <= end_wait | end_sleep | wfe_done | (WFE_I & any_evt & ~evt_latch_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Configuration traps
   reg stack_pad_r;
   reg stk9_r;
   reg restore_r;
   reg lockup_r;
   reg bf_ign_r;
   reg div_trap_r;
   reg div_zero_r;
   reg usage_r;
   reg trig_ok_r;
   reg trig_no_r;
   reg thr_ok_r;
   reg thr_flt_r;
   // Each trap answer except the sticky lock-up is a one-cycle pulse one clock after its request
   wire trig_perm = ~TRIG_UNPRIV_I | cc_r[`SEC_CC_UNPRIV_TRIG];
   wire thr_perm  = ~OTHER_ACTIVE_I | cc_r[`SEC_CC_THREAD_ANY];
   always @(posedge CORE_CLK_I) begin
      if (SRST_I) begin
         stack_pad_r <= 1'b0;
         stk9_r      <= 1'b0;
         restore_r   <= 1'b0;
         lockup_r    <= 1'b0;
         bf_ign_r    <= 1'b0;
         div_trap_r  <= 1'b0;
         div_zero_r  <= 1'b0;
         usage_r     <= 1'b0;
         trig_ok_r   <= 1'b0;
         trig_no_r   <= 1'b0;
         thr_ok_r    <= 1'b0;
         thr_flt_r   <= 1'b0;
      end else begin
         stack_pad_r <= EXC_ENTRY_I & cc_r[`SEC_CC_STACK_ALIGN] & SP_BIT2_I;
         stk9_r      <= EXC_ENTRY_I & cc_r[`SEC_CC_STACK_ALIGN] & SP_BIT2_I;
         restore_r   <= EXCEPTION_RETURN_VALUE_I & STACKED_BIT9_I;
         // Lock-up is sticky until reset; the core cannot recover on its own
         if (DBUS_FAULT_I && ELEVATED_PRI_I && !cc_r[`SEC_CC_BF_IGNORE]) begin
            lockup_r <= 1'b1;
         end
         bf_ign_r    <= DBUS_FAULT_I & ELEVATED_PRI_I & cc_r[`SEC_CC_BF_IGNORE];
         div_trap_r  <= DIV_ZERO_I & cc_r[`SEC_CC_DIV0];
         div_zero_r  <= DIV_ZERO_I & ~cc_r[`SEC_CC_DIV0];
         usage_r     <= MISALIGNED_I & (MULTI_DOUBLE_I | cc_r[`SEC_CC_MISALIGN]);
         trig_ok_r   <= TRIG_ACCESS_I & trig_perm;
         trig_no_r   <= TRIG_ACCESS_I & ~trig_perm;
         thr_ok_r    <= THREAD_RET_I & thr_perm;
         thr_flt_r   <= THREAD_RET_I & ~thr_perm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign PREADY_O           = pready_r;
   assign PRDATA_O           = prdata_r;
   assign PSLVERR_O          = pslverr_r;
   assign PREEMPT_O          = preempt_r;
   assign GROUP_PRI_A_O      = grp_a_r;
   assign SUB_PRI_A_O        = sub_a_r;
   // Handler fields 4, 5, 6, 11, 14 and 15 sit in entries 0, 1, 2, 7, 10 and 11
   assign PRI_MEMFAULT_O     = hpri_r[0];
   assign PRI_BUSFAULT_O     = hpri_r[1];
   assign PRI_USAGE_O        = hpri_r[2];
   assign PRI_SVCALL_O       = hpri_r[7];
   assign PRI_PENDSV_O       = hpri_r[10];
   assign PRI_SYSTICK_O      = hpri_r[11];
   assign WAKE_O             = wake_r;
   assign SLEEPING_O         = sleeping_r;
   assign DEEP_SLEEP_O       = deep_out_r;
   assign STACK_PAD_O        = stack_pad_r;
   assign STACKED_BIT9_O     = stk9_r;
   assign RESTORE_PAD_O      = restore_r;
   assign LOCKUP_O           = lockup_r;
   assign BUSFAULT_IGNORED_O = bf_ign_r;
   assign DIV_TRAP_O         = div_trap_r;
   assign DIV_QUOT_ZERO_O    = div_zero_r;
   assign USAGE_FAULT_O      = usage_r;
   assign TRIG_ALLOW_O       = trig_ok_r;
   assign TRIG_DENY_O        = trig_no_r;
   assign THREAD_OK_O        = thr_ok_r;
   assign THREAD_FAULT_O     = thr_flt_r;

endmodule // sec_ctrl

`default_nettype wire

/* File: sec_ctrl_bench.sv */
// Self-checking bench of the system exception control block
`timescale 1ns/1ps
`default_nettype none
module sec_ctrl_bench;
   logic        CORE_CLK_I = 1'b0, SRST_I = 1'b1;
   logic        PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
   logic [11:0] PADDR_I = 12'h000;
   logic [31:0] PWDATA_I = 32'h0, r, d, cc_m = 32'h0, lp_m = 32'h0;
   logic [31:0] hp_m[3] = '{32'h0, 32'h0, 32'h0};
   logic [31:0] hm[3] = '{32'h00f0_f0f0, 32'hf000_0000, 32'hf0f0_0000};
   logic [3:0]  PSTRB_I = 4'h0, s;
   logic [7:0]  CMP_PRI_A_I = 8'h00, CMP_PRI_B_I = 8'h00, a, b, gm;
   logic [19:0] cin = 20'h0, v;
   logic        e;
   logic [11:0] te;
   int          miscompares = 0, n_compared = 0, n, k, g;
   wire         PREADY_O, PSLVERR_O, PREEMPT_O;
   wire  [31:0] PRDATA_O;
   wire  [7:0]  GROUP_PRI_A_O, SUB_PRI_A_O, PRI_MEMFAULT_O, PRI_BUSFAULT_O, PRI_USAGE_O;
   wire  [7:0]  PRI_SVCALL_O, PRI_PENDSV_O, PRI_SYSTICK_O;
   wire         IRQ_PEND_SET_I, IRQ_PEND_EN_I, EVT_PEND_SET_I, SEV_I, EXT_EVENT_I, WFE_I;
   wire         RET_TO_THREAD_I, EXC_ENTRY_I, SP_BIT2_I, EXCEPTION_RETURN_VALUE_I, STACKED_BIT9_I;
   wire         DBUS_FAULT_I, ELEVATED_PRI_I, DIV_ZERO_I, MISALIGNED_I, MULTI_DOUBLE_I;
   wire         TRIG_ACCESS_I, TRIG_UNPRIV_I, THREAD_RET_I, OTHER_ACTIVE_I;
   wire         WAKE_O, SLEEPING_O, DEEP_SLEEP_O, STACK_PAD_O, STACKED_BIT9_O, RESTORE_PAD_O;
   wire         LOCKUP_O, BUSFAULT_IGNORED_O, DIV_TRAP_O, DIV_QUOT_ZERO_O, USAGE_FAULT_O;
   wire         TRIG_ALLOW_O, TRIG_DENY_O, THREAD_OK_O, THREAD_FAULT_O;
   wire  [14:0] cout = {WAKE_O, SLEEPING_O, DEEP_SLEEP_O, STACK_PAD_O, STACKED_BIT9_O,
      RESTORE_PAD_O, LOCKUP_O, BUSFAULT_IGNORED_O, DIV_TRAP_O, DIV_QUOT_ZERO_O,
      USAGE_FAULT_O, TRIG_ALLOW_O, TRIG_DENY_O, THREAD_OK_O, THREAD_FAULT_O};
   // Core-side strobes packed so one assignment launches a whole stimulus
   assign {IRQ_PEND_SET_I, IRQ_PEND_EN_I, EVT_PEND_SET_I, SEV_I, EXT_EVENT_I, WFE_I,
      RET_TO_THREAD_I, EXC_ENTRY_I, SP_BIT2_I, EXCEPTION_RETURN_VALUE_I, STACKED_BIT9_I, DBUS_FAULT_I,
      ELEVATED_PRI_I, DIV_ZERO_I, MISALIGNED_I, MULTI_DOUBLE_I, TRIG_ACCESS_I,
      TRIG_UNPRIV_I, THREAD_RET_I, OTHER_ACTIVE_I} = cin;
   sec_ctrl i_sec_ctrl (.*);
   always #12.5 CORE_CLK_I = ~CORE_CLK_I;
   ////////////////////////////////////////////////////////////////////////////////
   task wrap_up;
      $display("compared %0d, wrong %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   // Waits on pready with no assumed latency; ready high or the 20-cycle count limit ends it
   task apb(input logic w, input logic [11:0] ad, input logic [31:0] wd,
            input logic [3:0] st, output logic [31:0] rd, output logic er);
      int t;
      @(posedge CORE_CLK_I);
      {PSEL_I, PENABLE_I, PWRITE_I, PADDR_I, PWDATA_I, PSTRB_I} <= {2'b10, w, ad, wd, st};
      @(posedge CORE_CLK_I);
      PENABLE_I <= 1'b1;
      t = 0;
      do begin
         @(posedge CORE_CLK_I);
         t++;
      end while (PREADY_O !== 1'b1 && t < 20);
      if (t >= 20) begin
         miscompares++;
         $display("wrong value at %0t: no ready answer", $time);
      end
      rd = PRDATA_O;
      er = PSLVERR_O;
      {PSEL_I, PENABLE_I} <= 2'b00;
   endtask
   task step(input logic [19:0] x);
      @(posedge CORE_CLK_I);
      cin <= x;
      @(posedge CORE_CLK_I);
      cin <= 20'h0;
      #1;
   endtask
   task lps(input logic [19:0] x, input logic [2:0] q);
      step(x);
      chk(cout[14:12], q, "low power");
   endtask
   function automatic logic [31:0] mrg(logic [31:0] o, logic [31:0] w, logic [3:0] st,
                                       logic [31:0] m);
      for (int i = 0; i < 4; i++) if (st[i]) o[8 * i +: 8] = w[8 * i +: 8];
      return o & m;
   endfunction
   function automatic logic [11:0] trap_exp(logic [19:0] x, logic [31:0] c);
      return {x[12] & x[11] & c[9], x[12] & x[11] & c[9], x[10] & x[9], 1'b0,
         x[8] & x[7] & c[8], x[6] & c[4], x[6] & ~c[4], x[5] & (x[4] | c[3]),
         x[3] & (~x[2] | c[1]), x[3] & x[2] & ~c[1], x[1] & (~x[0] | c[0]),
         x[1] & x[0] & ~c[0]};
   endfunction
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #500000;
      miscompares++;
      wrap_up();
   end
   initial begin
      r = $urandom(40);
      repeat (16) @(posedge CORE_CLK_I);
      SRST_I <= 1'b0;
      for (int i = 0; i < 7; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0, 4'h0, r, e);
         chk(r, (i == 0) ? 32'hfa05_0000 : 32'h0, "reset read");
         chk(32'(e), 32'(i == 6), "slave error");
      end
      apb(1'b1, 12'h000, 32'h05fb_0500, 4'hf, r, e);
      apb(1'b0, 12'h000, 32'h0, 4'h0, r, e);
      chk(r, 32'hfa05_0000, "bad key");
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, 12'h000, {16'h05fa, 5'h00, 3'(c), 8'h00}, 4'hf, r, e);
         apb(1'b0, 12'h000, 32'h0, 4'h0, r, e);
         chk(r, {16'hfa05, 5'h00, 3'(c), 8'h00}, "split code");
         g = (c < 3) ? 4 : 7 - c;
         gm = ~(8'hff >> g);
         for (int j = 0; j < 4; j++) begin
            a = 8'($urandom);
            b = j[0] ? a ^ 8'h10 : 8'($urandom);
            @(posedge CORE_CLK_I);
            {CMP_PRI_A_I, CMP_PRI_B_I} <= {a, b};
            @(posedge CORE_CLK_I);
            #1;
            chk({GROUP_PRI_A_O, SUB_PRI_A_O, PREEMPT_O},
               {a & gm, a & ~gm & 8'hf0, (a & gm) < (b & gm)}, "split");
         end
      end
      for (int i = 0; i < 40; i++) begin
         k = $urandom_range(2);
         s = 4'($urandom);
         d = $urandom;
         apb(1'b1, 12'h008, d, s, r, e);
         cc_m = mrg(cc_m, d, s, 32'h0000_031b);
         apb(1'b1, 12'h004, ~d, s, r, e);
         lp_m = mrg(lp_m, ~d, s, 32'h0000_0016);
         apb(1'b1, 12'(12 + 4 * k), d, s, r, e);
         hp_m[k] = mrg(hp_m[k], d, s, hm[k]);
         apb(1'b0, 12'h004, 32'h0, 4'h0, r, e);
         chk(r, lp_m, "low power reg");
         apb(1'b0, 12'h008, 32'h0, 4'h0, r, e);
         chk(r, cc_m, "config reg");
         apb(1'b0, 12'(12 + 4 * k), 32'h0, 4'h0, r, e);
         chk(r, hp_m[k], "priority reg");
         chk({PRI_SYSTICK_O, PRI_PENDSV_O, PRI_SVCALL_O, PRI_USAGE_O},
            {hp_m[2][31:16], hp_m[1][31:24], hp_m[0][23:16]}, "pri ports");
         chk({PRI_BUSFAULT_O, PRI_MEMFAULT_O}, hp_m[0][15:0], "pri ports");
         v = 20'($urandom) & 20'h01fff;
         if (!cc_m[8]) v[8] = 1'b0;
         step(v);
         te = trap_exp(v, cc_m);
         chk(cout[14:6], {3'b000, te[11:6]}, "trap");
         chk(cout[5:0], te[5:0], "trap");
      end
      apb(1'b1, 12'h004, 32'h0, 4'hf, r, e);
      lps(20'h04000, 3'b010);
      lps(20'h10000, 3'b100);
      lps(20'h20000, 3'b000);
      lps(20'h04000, 3'b100);
      lps(20'h04000, 3'b010);
      lps(20'h80000, 3'b010);
      lps(20'hc0000, 3'b100);
      lps(20'h04000, 3'b010);
      lps(20'h08000, 3'b010);
      n = 0;
      while (WAKE_O !== 1'b1 && n < 8) begin
         @(posedge CORE_CLK_I);
         #1;
         n++;
      end
      chk(32'(WAKE_O), 32'h1, "external event wake");
      apb(1'b1, 12'h004, 32'h14, 4'h1, r, e);
      lps(20'h04000, 3'b011);
      lps(20'h80000, 3'b100);
      apb(1'b1, 12'h004, 32'h02, 4'h1, r, e);
      lps(20'h02000, 3'b010);
      lps(20'h20000, 3'b100);
      apb(1'b1, 12'h004, 32'h0, 4'h1, r, e);
      lps(20'h02000, 3'b000);
      apb(1'b1, 12'h008, 32'h0, 4'hf, r, e);
      step(20'h00180);
      chk(32'(LOCKUP_O), 32'h1, "lockup");
      step(20'h0);
      chk(32'(LOCKUP_O), 32'h1, "lockup held");
      wrap_up();
   end
endmodule // sec_ctrl_bench
bind sec_ctrl sec_ctrl_checker i_sec_ctrl_checker (.*);
`default_nettype wire

/* File: sec_ctrl_checker.sv */
// Port-level assertions for the system exception control block
`timescale 1ns/1ps
`default_nettype none
module sec_ctrl_checker (
   input wire logic       CORE_CLK_I,
   input wire logic       SRST_I,
   input wire logic [7:0] CMP_PRI_A_I,
   input wire logic [7:0] CMP_PRI_B_I,
   input wire logic       PREEMPT_O,
   input wire logic [7:0] GROUP_PRI_A_O,
   input wire logic [7:0] SUB_PRI_A_O,
   input wire logic [7:0] PRI_SVCALL_O,
   input wire logic [7:0] PRI_SYSTICK_O,
   input wire logic       EVT_PEND_SET_I,
   input wire logic       SLEEPING_O,
   input wire logic       WAKE_O,
   input wire logic       DEEP_SLEEP_O,
   input wire logic       LOCKUP_O,
   input wire logic       DIV_ZERO_I,
   input wire logic       DIV_TRAP_O,
   input wire logic       DIV_QUOT_ZERO_O,
   input wire logic       MISALIGNED_I,
   input wire logic       MULTI_DOUBLE_I,
   input wire logic       USAGE_FAULT_O,
   input wire logic       THREAD_RET_I,
   input wire logic       OTHER_ACTIVE_I,
   input wire logic       THREAD_OK_O,
   input wire logic       EXC_ENTRY_I,
   input wire logic       SP_BIT2_I,
   input wire logic       STACK_PAD_O,
   input wire logic       STACKED_BIT9_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (SRST_I);
   ////////////////////////////////////////////////////////////////////////////////
   split_sum_a: assert property (
      1'b1 |=> (GROUP_PRI_A_O | SUB_PRI_A_O) == ($past(CMP_PRI_A_I) & 8'hf0)
      && (GROUP_PRI_A_O & SUB_PRI_A_O) == 8'h00) else $error("split parts wrong");
   preempt_grp_a: assert property (
      CMP_PRI_A_I[7:4] >= CMP_PRI_B_I[7:4] |=> !PREEMPT_O) else $error("bad preempt");
   pri_low_a: assert property (
      (PRI_SVCALL_O[3:0] | PRI_SYSTICK_O[3:0]) == 4'h0) else $error("low priority bits set");
   evt_wake_a: assert property (
      SLEEPING_O && EVT_PEND_SET_I |=> WAKE_O && !SLEEPING_O) else $error("no wake");
   deep_sleep_a: assert property (
      DEEP_SLEEP_O |-> SLEEPING_O) else $error("deep without sleep");
   lock_stick_a: assert property (
      LOCKUP_O |=> LOCKUP_O) else $error("lockup dropped");
   div_one_a: assert property (
      DIV_ZERO_I |=> DIV_TRAP_O != DIV_QUOT_ZERO_O) else $error("divide outcome");
   multi_fault_a: assert property (
      MISALIGNED_I && MULTI_DOUBLE_I |=> USAGE_FAULT_O) else $error("no usage fault");
   thread_base_a: assert property (
      THREAD_RET_I && !OTHER_ACTIVE_I |=> THREAD_OK_O) else $error("thread entry refused");
   stack_pad_a: assert property (
      STACK_PAD_O |-> STACKED_BIT9_O && $past(EXC_ENTRY_I) && $past(SP_BIT2_I))
      else $error("pad without cause");
endmodule // sec_ctrl_checker
`default_nettype wire

/* File: sec_defines.vh */
// Register map, field positions and reset values of the system exception control block
`ifndef SEC_DEFINES_VH
`define SEC_DEFINES_VH

`define SEC_ADDR_W          12
`define SEC_OFS_SPLIT       12'h000
`define SEC_OFS_LPCTRL      12'h004
`define SEC_OFS_CFGCTRL     12'h008
`define SEC_OFS_HPRI1       12'h00c
`define SEC_OFS_HPRI2       12'h010
`define SEC_OFS_HPRI3       12'h014

`define SEC_KEY_WRITE       16'h05fa
`define SEC_KEY_READ        16'hfa05
`define SEC_SPLIT_LSB       8
`define SEC_SPLIT_MSB       10
`define SEC_SPLIT_RST       3'h0

`define SEC_LP_ON_RETURN    1
`define SEC_LP_DEEP         2
`define SEC_LP_ANY_PEND     4
`define SEC_LP_MASK         32'h0000_0016

`define SEC_CC_THREAD_ANY   0
`define SEC_CC_UNPRIV_TRIG  1
`define SEC_CC_MISALIGN     3
`define SEC_CC_DIV0         4
`define SEC_CC_BF_IGNORE    8
`define SEC_CC_STACK_ALIGN  9
`define SEC_CC_MASK         32'h0000_031b
`define SEC_CC_RST          32'h0000_0000

`define SEC_PRI_IMPL_MASK   8'hf0
`define SEC_PRI_RST         8'h00
`endif
